// [verilog/wake_pkg.sv]
// Package for the suspend/wake-up detector: register map, modes, timing
package wake_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each, except OFS_INT_MASK at 0x1 inside the first word)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_WAKE_EN = 4'h0;
  localparam logic [3:0] OFS_EDGE_SEL = 4'h4;
  localparam logic [3:0] OFS_SR_CTRL = 4'h8;
  localparam logic [3:0] OFS_INT_STATUS = 4'hC;
  localparam logic [3:0] OFS_INT_MASK = 4'h1;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // Wake enable bit positions
  // ----------------------------------------------------------------
  localparam int WB_MAINS = 0;
  localparam int WB_BATT0 = 1;
  localparam int WB_BATT1 = 2;
  localparam int WB_BATT2 = 3;
  localparam int WB_TIMER = 4;
  localparam int WB_IRQ0 = 5;
  localparam int WB_SEL = 8;
  localparam int WB_RING = 9;
  localparam int WB_RXD = 10;
  localparam int WB_SR = 11;
  localparam int WAKE_W = 12;

  // Suspend/resume control fields
  localparam int SR_SUS_EN = 0;
  localparam int SR_RES_EN = 1;
  localparam int SR_SUS_RISE = 2;
  localparam int SR_RES_RISE = 3;
  localparam int SR_TOGGLE = 4;
  localparam int SR_TOG_RISE = 5;
  localparam int SR_LIMIT_L1 = 6;
  localparam int SR_LIMIT_L2 = 7;
  localparam logic [7:0] SR_CTRL_RST = 8'h00;

  // Interrupt status bits
  localparam int IS_WAKE = 0;
  localparam int IS_SUSP = 1;
  localparam int IS_W = 2;

  // ----------------------------------------------------------------
  // Power modes and wake sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_HYPER = 3'h0,
    MODE_HIGH = 3'h1,
    MODE_LOW = 3'h2,
    MODE_STANDBY = 3'h3,
    MODE_SUSPEND = 3'h4,
    MODE_TEMP_LOW = 3'h5
  } mode_e;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_RECLOCK = 3'h1,
    SEQ_PLL = 3'h2,
    SEQ_GATE = 3'h3,
    SEQ_RESUME = 3'h4
  } seq_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int DEBOUNCE_MS = 15;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;

endpackage : wake_pkg

// [verilog/suspend_wakeup_detect.sv]
// Wake-up and suspend/resume detection of the power mode unit
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Wake acted on only in Suspend
// R2: Wake also from Temporary Low-Speed entered from Suspend
// R3: Reclock, restart PLLs, gate clocks, then resume
// R4: Mains-present either edge can wake
// R5: Any battery-low either edge can wake
// R6: Battery-low limit targets Low-Speed not High
// R7: Suspend/resume pin disabled after reset
// R8: Pin also feeds keyboard row input
// R9: Pin causes suspend, resume, both or neither
// R10: Selectable edges, plus toggle mode
// R11: Pin debounced 15 ms before acting
// R12: Only Suspend counts as suspended
// R13: Suspend timer expiry can wake
// R14: Enabled external interrupt rising edge wakes
// R15: Multipurpose select pin falling edge wakes
// R16: Serial ring and receive falling edges wake
// R17: Each source gated by own enable bit; the pin resume uses SR_RES_EN not WB_SR, and all select pins share WB_SEL
// R18: Outside sources hold levels two clocks
module suspend_wakeup_detect import wake_pkg::*; #(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int SEL_PINS = 15
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  input wire logic MAINS_PRESENT_IN_I,
  input wire logic BATTERY_LOW_LEVEL0_I,
  input wire logic BATTERY_LOW_LEVEL1_I,
  input wire logic BATTERY_LOW_LEVEL2_I,
  input wire logic SUSPEND_RESUME_PIN_I,
  input wire logic [2:0] EXT_INTERRUPT_LINES_I,
  input wire logic [2:0] EXT_IRQ_READY_I,
  input wire logic [SEL_PINS-1:0] MULTIPURPOSE_SELECT_PINS_I,
  input wire logic SERIAL_RING_INDICATE_I,
  input wire logic SERIAL_RECEIVE_LINE_I,
  input wire logic SUSPEND_TIMER_EXPIRED_I,
  input wire logic [2:0] CURRENT_MODE_I,
  input wire logic TEMP_LOW_FROM_SUSPEND_I,
  input wire logic PLL_PROGRAMMED_OFF_I,
  output logic KEYBOARD_ROW_O,
  output logic CLOCK_RESTART_O,
  output logic PLL_START_O,
  output logic CLOCK_GATE_O,
  output logic RESUME_REQ_O,
  output logic [2:0] TARGET_MODE_O,
  output logic FORCE_SUSPEND_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 11 + SEL_PINS;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] prev_ff;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;

  assign pins_raw = {MULTIPURPOSE_SELECT_PINS_I, SUSPEND_TIMER_EXPIRED_I,
                     SERIAL_RECEIVE_LINE_I, SERIAL_RING_INDICATE_I,
                     EXT_INTERRUPT_LINES_I, SUSPEND_RESUME_PIN_I,
                     BATTERY_LOW_LEVEL2_I, BATTERY_LOW_LEVEL1_I,
                     BATTERY_LOW_LEVEL0_I, MAINS_PRESENT_IN_I};

  // The unit clock is always on, so detection works with main clocks off
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin // [R18]
    if (!RESET_N_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [WAKE_W-1:0] wake_en_ff;
  logic [3:0] edge_rise_ff;
  logic [3:0] edge_fall_ff;
  logic [7:0] sr_ctrl_ff;
  logic [IS_W-1:0] int_status_ff;
  logic [IS_W-1:0] int_mask_ff;
  logic [31:0] readdata_ff;
  logic wait_ff;
  logic wr_hit;
  logic rd_hit;
  logic [IS_W-1:0] ev_set;

  assign wr_hit = WRITE_I && !wait_ff;
  assign rd_hit = READ_I && wait_ff;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wait_ff <= 1'b1;
    end else if ((READ_I || WRITE_I) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wake_en_ff <= '0;
      edge_rise_ff <= '0;
      edge_fall_ff <= '0;
      sr_ctrl_ff <= SR_CTRL_RST; // [R7]
      int_mask_ff <= '0;
    end else if (wr_hit) begin
      case (ADDRESS_I)
        OFS_WAKE_EN: wake_en_ff <= WRITEDATA_I[WAKE_W-1:0];
        OFS_EDGE_SEL: begin
          edge_rise_ff <= WRITEDATA_I[3:0];
          edge_fall_ff <= WRITEDATA_I[11:8];
        end
        OFS_SR_CTRL: sr_ctrl_ff <= WRITEDATA_I[7:0];
        OFS_INT_MASK: int_mask_ff <= WRITEDATA_I[IS_W-1:0];
        default: ;
      endcase
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      int_status_ff <= '0;
    end else begin
      int_status_ff <= (int_status_ff &
                        ~((wr_hit && ADDRESS_I == OFS_INT_STATUS) ?
                          WRITEDATA_I[IS_W-1:0] : '0)) | ev_set;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      readdata_ff <= '0;
    end else if (rd_hit) begin
      case (ADDRESS_I)
        OFS_WAKE_EN: readdata_ff <= {20'h00000, wake_en_ff};
        OFS_EDGE_SEL: readdata_ff <= {20'h00000, edge_fall_ff, 4'h0, edge_rise_ff};
        OFS_SR_CTRL: readdata_ff <= {24'h000000, sr_ctrl_ff};
        OFS_INT_STATUS: readdata_ff <= {30'h0, int_status_ff};
        OFS_INT_MASK: readdata_ff <= {30'h0, int_mask_ff};
        default: readdata_ff <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Suspend/resume pin debounce
  // ----------------------------------------------------------------
  localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
  logic [DB_W-1:0] db_cnt_ff;
  logic db_level_ff;
  logic db_rise;
  logic db_fall;
  logic sr_raw;

  assign sr_raw = sync2_ff[4];

  // Level must hold steady a full 15 ms before it is accepted
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin // [R11]
    if (!RESET_N_I) begin
      db_cnt_ff <= '0;
      db_level_ff <= 1'b0;
    end else if (sr_raw == db_level_ff) begin
      db_cnt_ff <= '0;
    end else if (db_cnt_ff == DB_W'(DEBOUNCE_CYCLES - 1)) begin
      db_cnt_ff <= '0;
      db_level_ff <= sr_raw;
    end else begin
      db_cnt_ff <= db_cnt_ff + 1'b1;
    end
  end

  assign db_rise = (sr_raw != db_level_ff) && !db_level_ff &&
                   db_cnt_ff == DB_W'(DEBOUNCE_CYCLES - 1);
  assign db_fall = (sr_raw != db_level_ff) && db_level_ff &&
                   db_cnt_ff == DB_W'(DEBOUNCE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Mode classification and wake events
  // ----------------------------------------------------------------
  logic suspended;
  logic wake_window;
  logic [3:0] power_edge;
  logic src_wake;
  logic sr_sus_ev;
  logic sr_res_ev;
  logic tog_edge;

  assign suspended = CURRENT_MODE_I == MODE_SUSPEND; // [R12]
  assign wake_window = suspended ||
                       (CURRENT_MODE_I == MODE_TEMP_LOW && TEMP_LOW_FROM_SUSPEND_I); // [R1] [R2]

  assign power_edge = (rise[3:0] & edge_rise_ff) | (fall[3:0] & edge_fall_ff); // [R4] [R5]
  assign src_wake = |(power_edge & wake_en_ff[3:0]) |
                    (wake_en_ff[WB_TIMER] && rise[10]) | // [R13]
                    |(rise[7:5] & EXT_IRQ_READY_I & wake_en_ff[7:5]) | // [R14]
                    (wake_en_ff[WB_SEL] && |fall[NSYNC-1:11]) | // [R15]
                    (wake_en_ff[WB_RING] && fall[8]) |
                    (wake_en_ff[WB_RXD] && fall[9]); // [R16] [R17]

  assign tog_edge = sr_ctrl_ff[SR_TOG_RISE] ? db_rise : db_fall;
  // Toggle takes precedence over the separate edge settings
  assign sr_sus_ev = sr_ctrl_ff[SR_SUS_EN] && !wake_window &&
                     (sr_ctrl_ff[SR_TOGGLE] ? tog_edge :
                      (sr_ctrl_ff[SR_SUS_RISE] ? db_rise : db_fall)); // [R9] [R10]
  assign sr_res_ev = sr_ctrl_ff[SR_RES_EN] &&
                     (sr_ctrl_ff[SR_TOGGLE] ? tog_edge :
                      (sr_ctrl_ff[SR_RES_RISE] ? db_rise : db_fall)); // [R9] [R10]

  // ----------------------------------------------------------------
  // Wake sequence
  // ----------------------------------------------------------------
  seq_e seq_ff;
  logic wake_go;
  logic [2:0] target_ff;
  logic restart_ff;
  logic pll_ff;
  logic gate_ff;
  logic resume_ff;
  logic force_sus_ff;
  logic kb_row_ff;

  assign wake_go = wake_window && (src_wake || sr_res_ev) && seq_ff == SEQ_IDLE; // [R1]
  assign ev_set = {sr_sus_ev, wake_go};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin // [R3]
    if (!RESET_N_I) begin
      seq_ff <= SEQ_IDLE;
    end else begin
      case (seq_ff)
        SEQ_IDLE: if (wake_go) seq_ff <= SEQ_RECLOCK;
        SEQ_RECLOCK: seq_ff <= PLL_PROGRAMMED_OFF_I ? SEQ_PLL : SEQ_GATE;
        SEQ_PLL: seq_ff <= SEQ_GATE;
        SEQ_GATE: seq_ff <= SEQ_RESUME;
        SEQ_RESUME: seq_ff <= SEQ_IDLE;
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      restart_ff <= 1'b0;
      pll_ff <= 1'b0;
      gate_ff <= 1'b0;
      resume_ff <= 1'b0;
      force_sus_ff <= 1'b0;
      target_ff <= MODE_HIGH;
      kb_row_ff <= 1'b0;
    end else begin
      restart_ff <= wake_go; // [R3]
      pll_ff <= seq_ff == SEQ_RECLOCK && PLL_PROGRAMMED_OFF_I;
      gate_ff <= seq_ff == SEQ_RECLOCK && !PLL_PROGRAMMED_OFF_I || seq_ff == SEQ_PLL;
      resume_ff <= seq_ff == SEQ_GATE;
      force_sus_ff <= sr_sus_ev;
      kb_row_ff <= sr_raw; // [R8]
      if (wake_go) begin
        target_ff <= ((sr_ctrl_ff[SR_LIMIT_L1] && sync2_ff[2]) ||
                      (sr_ctrl_ff[SR_LIMIT_L2] && sync2_ff[3])) ? MODE_LOW : MODE_HIGH; // [R6]
      end
    end
  end

  logic irq_ff;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  assign READDATA_O = readdata_ff;
  assign WAITREQUEST_O = wait_ff;
  assign KEYBOARD_ROW_O = kb_row_ff;
  assign CLOCK_RESTART_O = restart_ff;
  assign PLL_START_O = pll_ff;
  assign CLOCK_GATE_O = gate_ff;
  assign RESUME_REQ_O = resume_ff;
  assign TARGET_MODE_O = target_ff;
  assign FORCE_SUSPEND_O = force_sus_ff;
  assign IRQ_O = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wake_only_window: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    wake_go |-> wake_window) else $error("wake outside suspend"); // [R1]
  a_temp_low_wake: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (seq_ff == SEQ_IDLE && CURRENT_MODE_I == MODE_TEMP_LOW && TEMP_LOW_FROM_SUSPEND_I
     && src_wake) |=> restart_ff) else $error("temp low wake lost"); // [R2]
  a_seq_order: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    restart_ff |-> ##[1:3] resume_ff) else $error("resume late"); // [R3]
  a_gate_before_resume: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    resume_ff |-> $past(gate_ff)) else $error("resume without gate"); // [R3]
  a_target_limit: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (wake_go && sr_ctrl_ff[SR_LIMIT_L1] && sync2_ff[2]) |=> target_ff == MODE_LOW)
    else $error("limit ignored"); // [R6]
  a_sr_disabled: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    !sr_ctrl_ff[SR_SUS_EN] |=> !force_sus_ff) else $error("pin forced suspend"); // [R7]
  a_kb_follow: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    kb_row_ff == $past(sync2_ff[4])) else $error("keyboard row stale"); // [R8]
  a_debounce_hold: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    $changed(db_level_ff) |-> $past(sr_raw != db_level_ff, 2))
    else $error("debounce early"); // [R11]
  c_wake: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) resume_ff);
  c_pll: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) pll_ff);
  c_force: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) force_sus_ff);

endmodule : suspend_wakeup_detect

// [bench/power_status_model.sv]
// Model of the power-status comparators and the suspend/resume switch
`timescale 1ns/1ps
module power_status_model (
  input wire logic clk_i,
  output logic mains_o,
  output logic [2:0] batt_o,
  output logic pin_o
);
  initial begin
    mains_o = 1'b0;
    batt_o = 3'h0;
    pin_o = 1'b0;
  end
  // Each new level stays put for three clocks so no transition is lost
  task automatic flip_level(input int k);
    @(posedge clk_i);
    if (k == 0) begin
      mains_o <= ~mains_o;
    end else begin
      batt_o[k-1] <= ~batt_o[k-1];
    end
    repeat (3) @(posedge clk_i);
  endtask : flip_level
  // The switch may bounce, so short presses are allowed here
  task automatic press(input logic lvl, input int hold);
    @(posedge clk_i);
    pin_o <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask : press
endmodule : power_status_model

// [bench/suspend_wakeup_detect_bench.sv]
// Self-checking bench for the suspend/wake-up detector
`timescale 1ns/1ps
module suspend_wakeup_detect_bench import wake_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq, kb, c_rst, c_pll, c_gate, c_res, c_sus, irq, mains, pin;
  logic [2:0] target, batt;
  logic [6:0] aux = 7'h70;
  logic [2:0] irq_rdy = 3'h7;
  logic [2:0] mode = 3'h1;
  logic tlfs = 1'b0;
  logic plloff = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_rst, n_pll, n_res, n_sus, t_rst, t_pll, t_gate, t_res;
  always #25 clk = ~clk;

  power_status_model psm (.clk_i(clk), .mains_o(mains), .batt_o(batt), .pin_o(pin));
  suspend_wakeup_detect #(.DEBOUNCE_CYCLES(4), .SEL_PINS(15)) dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr),
    .WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(waitreq),
    .MAINS_PRESENT_IN_I(mains), .BATTERY_LOW_LEVEL0_I(batt[0]),
    .BATTERY_LOW_LEVEL1_I(batt[1]), .BATTERY_LOW_LEVEL2_I(batt[2]),
    .SUSPEND_RESUME_PIN_I(pin), .EXT_INTERRUPT_LINES_I(aux[3:1]), .EXT_IRQ_READY_I(irq_rdy),
    .MULTIPURPOSE_SELECT_PINS_I({14'h3FFF, aux[4]}), .SERIAL_RING_INDICATE_I(aux[5]),
    .SERIAL_RECEIVE_LINE_I(aux[6]), .SUSPEND_TIMER_EXPIRED_I(aux[0]),
    .CURRENT_MODE_I(mode), .TEMP_LOW_FROM_SUSPEND_I(tlfs), .PLL_PROGRAMMED_OFF_I(plloff),
    .KEYBOARD_ROW_O(kb), .CLOCK_RESTART_O(c_rst), .PLL_START_O(c_pll),
    .CLOCK_GATE_O(c_gate), .RESUME_REQ_O(c_res), .TARGET_MODE_O(target),
    .FORCE_SUSPEND_O(c_sus), .IRQ_O(irq));

  // ----------------------------------------------------------------
  // Pulse counters and time stamps
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (c_rst === 1'b1) begin
      n_rst <= n_rst + 1;
      t_rst <= cyc;
    end
    if (c_pll === 1'b1) begin
      n_pll <= n_pll + 1;
      t_pll <= cyc;
    end
    if (c_gate === 1'b1) begin
      t_gate <= cyc;
    end
    if (c_res === 1'b1) begin
      n_res <= n_res + 1;
      t_res <= cyc;
    end
    if (c_sus === 1'b1) begin
      n_sus <= n_sus + 1;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) chk("bus answer", 0, 1);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : bw

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask : rd_chk

  task automatic wake_case(input int k, input logic [2:0] m, input logic t, input logic p,
                           input int e);
    @(posedge clk);
    mode <= m;
    tlfs <= t;
    plloff <= p;
    n_rst = 0;
    n_pll = 0;
    n_res = 0;
    repeat (2) @(posedge clk);
    if (k < 4) begin
      psm.flip_level(k);
    end else begin
      aux[k-4] <= ~aux[k-4];
      repeat (3) @(posedge clk);
      aux[k-4] <= ~aux[k-4];
    end
    repeat (20) @(posedge clk);
    chk("clock restarts", e, n_rst);
    chk("resumes", e, n_res);
    if (e == 1) begin
      chk("pll starts", p, n_pll);
      chk("order", 1, t_rst < t_gate && t_res == t_gate + 1 &&
          (!p || (t_pll > t_rst && t_pll < t_gate)));
    end
  endtask : wake_case

  task automatic pin_case(input logic [7:0] sr, input logic [2:0] m, input int hold,
                          input int es, input int er);
    bw(OFS_SR_CTRL, {24'h0, sr});
    @(posedge clk);
    mode <= m;
    tlfs <= 1'b0;
    n_sus = 0;
    n_res = 0;
    psm.press(1'b1, hold);
    if (hold > 2) chk("keyboard row", 1, kb);
    psm.press(1'b0, 20);
    chk("forced suspends", es, n_sus);
    chk("pin resumes", er, n_res);
  endtask : pin_case

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk("waitrequest at reset", 1, waitreq);
    chk("target at reset", MODE_HIGH, target);
    chk("irq at reset", 0, irq);
    rd_chk(OFS_SR_CTRL, SR_CTRL_RST, "pin control");
    rd_chk(4'h2, 32'h0, "unmapped");
    pin_case(8'h00, MODE_HIGH, 20, 0, 0);
    bw(OFS_WAKE_EN, 32'hFFF);
    bw(OFS_EDGE_SEL, 32'hF0F);
    rd_chk(OFS_WAKE_EN, 32'hFFF, "wake enables");
    rd_chk(OFS_EDGE_SEL, 32'hF0F, "edge select");
    for (int k = 0; k < 11; k++) begin
      wake_case(k, k == 2 ? MODE_TEMP_LOW : MODE_SUSPEND, k == 2, k[0], 1);
    end
    wake_case(0, MODE_HIGH, 0, 0, 0);
    wake_case(0, MODE_TEMP_LOW, 0, 0, 0);
    irq_rdy <= 3'h0;
    wake_case(5, MODE_SUSPEND, 0, 0, 0);
    irq_rdy <= 3'h7;
    bw(OFS_WAKE_EN, 32'h0);
    wake_case(8, MODE_SUSPEND, 0, 0, 0);
    bw(OFS_WAKE_EN, 32'hFFF);
    chk("irq masked", 0, irq);
    bw(OFS_INT_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq unmasked", 1, irq);
    bw(OFS_INT_STATUS, 32'h3);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    rd_chk(OFS_INT_STATUS, 32'h0, "status");
    // Battery level 1 is high from the loop above
    bw(OFS_SR_CTRL, 32'h40);
    wake_case(0, MODE_SUSPEND, 0, 0, 1);
    chk("limited target", MODE_LOW, target);
    bw(OFS_SR_CTRL, 32'h0);
    wake_case(0, MODE_SUSPEND, 0, 0, 1);
    chk("full target", MODE_HIGH, target);
    bw(OFS_SR_CTRL, 32'h80);
    wake_case(0, MODE_SUSPEND, 0, 0, 1);
    chk("limited by level 2", MODE_LOW, target);
    for (int m = 0; m < 6; m++) begin
      pin_case(8'h05, m[2:0], 20, m != 4, 0);
    end
    pin_case(8'h05, MODE_HIGH, 2, 0, 0);
    pin_case(8'h0A, MODE_SUSPEND, 20, 0, 1);
    pin_case(8'h03, MODE_HIGH, 20, 1, 0);
    pin_case(8'h33, MODE_HIGH, 20, 1, 0);
    pin_case(8'h33, MODE_SUSPEND, 20, 0, 1);
    pin_case(8'h13, MODE_HIGH, 20, 1, 0);
    wrap_up();
  end
endmodule : suspend_wakeup_detect_bench
